//--- hw/serial_slave_memory_port.sv
// Purpose: Two-wire slave port giving byte access to 64 bytes of storage
// Assumes: Bus lines sampled by clk; supply_ok synchronised here
// Notes:   Tags below mark the logic of each rule
// Functional notes
// - Respond only to slave address D0h
// - Sixty-four bytes: clock bytes then RAM
// - Supply loss aborts transfer, clears pointer
// - Ignore bus while supply is low
// - Data changes only while clock low
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Bytes of eight plus acknowledge bit
// - Acknowledge each received byte low
// - Release data on master no-acknowledge
// - Random read via offset write, restart
// - Read pointer advances on master acknowledge
// - Read without offset uses held pointer
// - First write byte loads word offset
// - Acknowledge address and each write byte
// - Deselect and block writes on decay
`timescale 1ns/10ps
module serial_slave_memory_port
    import serial_port_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       supply_ok,
    output logic            sda_out,
    output logic            sda_oe,
    output logic [5:0]      word_offset,
    output logic            busy
);

    // ==========================================
    // State record
    typedef struct packed {
        bus_pins_t   s1;
        bus_pins_t   s2;
        bus_pins_t   prev;
        logic        pwr1;
        logic        pwr2;
        port_state_t state;
        logic [3:0]  bit_cnt;
        logic [7:0]  shreg;
        logic [5:0]  ptr;
        logic        rd_mode;
        logic        sda_oe;
        logic        busy;
        logic        offset_next;
        logic [MEM_DEPTH-1:0][7:0] mem;
    } state_s_t;

    state_s_t s_q;
    state_s_t s_d;

    // ==========================================
    // Helper functions
    function automatic logic [5:0] next_ptr(input logic [5:0] p);
        next_ptr = (p == PTR_LAST) ? PTR_RESET : p + 6'h01;
    endfunction : next_ptr

    // Open drain: enable the driver for a zero bit
    function automatic logic pull_low(input logic b);
        pull_low = ~b;
    endfunction : pull_low

    function automatic logic own_address(input logic [7:0] b);
        own_address = (b[7:1] == SLAVE_ADDR);
    endfunction : own_address

    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b);
        shift_in = {sr[6:0], b};
    endfunction : shift_in

    // ==========================================
    // Bus event detection
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic powered;

    always_comb begin
        scl_rise  = s_q.s2.scl & ~s_q.prev.scl;
        scl_fall  = ~s_q.s2.scl & s_q.prev.scl;
        // Clock high in two samples guards against skew
        // start detect
        start_det = s_q.s2.scl & s_q.prev.scl & s_q.prev.sda & ~s_q.s2.sda;
        stop_det  = s_q.s2.scl & s_q.prev.scl & ~s_q.prev.sda & s_q.s2.sda;
        powered   = s_q.pwr2;
    end

    // ==========================================
    // Next state
    always_comb begin
        s_d         = s_q;
        // Pins and supply pass two flops
        s_d.s1.scl  = scl_in;
        s_d.s1.sda  = sda_in;
        s_d.s2      = s_q.s1;
        s_d.prev    = s_q.s2;
        s_d.pwr1    = supply_ok;
        s_d.pwr2    = s_q.pwr1;

        // ==========================================
        // Supply and framing
        if (!powered) begin
            s_d.state   = ST_IDLE;
            s_d.ptr     = PTR_RESET;
            s_d.sda_oe  = 1'b0;
            s_d.bit_cnt = BIT_RESET;
            s_d.busy    = 1'b0;
            s_d.offset_next = 1'b0;
        end else if (stop_det) begin
            s_d.state  = ST_IDLE;
            s_d.sda_oe = 1'b0;
            s_d.busy   = 1'b0;
        end else if (start_det) begin
            s_d.state   = ST_ADDR;
            s_d.bit_cnt = BIT_RESET;
            s_d.sda_oe  = 1'b0;
            s_d.busy    = 1'b1;
            s_d.offset_next = 1'b0;
        end else begin
            // ==========================================
            // Byte engine
            case (s_q.state)
                ST_IDLE: begin
                    s_d.sda_oe = 1'b0;
                end

                ST_IGNORE: begin
                    s_d.sda_oe = 1'b0;
                end

                ST_ADDR: begin
                    if (scl_rise) begin
                        s_d.shreg   = shift_in(s_q.shreg, s_q.s2.sda);
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end
                    if (scl_fall && s_q.bit_cnt == 4'h8) begin
                        s_d.bit_cnt = BIT_RESET;
                        if (own_address(s_q.shreg)) begin
                            s_d.sda_oe  = 1'b1;
                            s_d.rd_mode = s_q.shreg[RW_BIT];
                            s_d.state   = ST_ADDR_ACK;
                        end else begin
                            s_d.state = ST_IGNORE;
                            s_d.busy  = 1'b0;
                        end
                    end
                end

                ST_OFFSET: begin
                    if (scl_rise) begin
                        s_d.shreg   = shift_in(s_q.shreg, s_q.s2.sda);
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end
                    if (scl_fall && s_q.bit_cnt == 4'h8) begin
                        s_d.bit_cnt = BIT_RESET;
                        s_d.sda_oe  = 1'b1;
                        s_d.state   = ST_WR_ACK;
                        if (s_q.offset_next) begin
                            s_d.ptr = s_q.shreg[5:0];
                        end else begin
                            // Reached only while powered
                            s_d.mem[s_q.ptr] = s_q.shreg;
                        end
                    end
                end

                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        s_d.bit_cnt = BIT_RESET;
                        if (s_q.rd_mode) begin
                            s_d.shreg  = s_q.mem[s_q.ptr];
                            s_d.sda_oe = pull_low(s_q.mem[s_q.ptr][7]);
                            s_d.state  = ST_TX;
                        end else begin
                            // Write frame: next byte is the offset
                            s_d.sda_oe      = 1'b0;
                            s_d.offset_next = 1'b1;
                            s_d.state       = ST_OFFSET;
                        end
                    end
                end

                ST_WR_ACK: begin
                    // Release after the clock fall, never while high
                    if (scl_fall) begin
                        s_d.sda_oe      = 1'b0;
                        s_d.offset_next = 1'b0;
                        if (!s_q.offset_next) begin
                            s_d.ptr = next_ptr(s_q.ptr);
                        end
                        s_d.state = ST_OFFSET;
                    end
                end

                ST_TX: begin
                    if (scl_fall) begin
                        if (s_q.bit_cnt == BIT_LAST) begin
                            s_d.sda_oe  = 1'b0;
                            s_d.bit_cnt = BIT_RESET;
                            s_d.state   = ST_TX_ACK;
                        end else begin
                            s_d.shreg   = {s_q.shreg[6:0], 1'b0};
                            s_d.sda_oe  = pull_low(s_q.shreg[6]);
                            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        if (!s_q.s2.sda) begin
                            s_d.ptr = next_ptr(s_q.ptr);
                            s_d.bit_cnt = 4'h1;
                        end else begin
                            s_d.state = ST_IGNORE;
                        end
                    end
                    if (scl_fall && s_q.bit_cnt == 4'h1) begin
                        s_d.shreg   = s_q.mem[s_q.ptr];
                        s_d.sda_oe  = pull_low(s_q.mem[s_q.ptr][7]);
                        s_d.bit_cnt = BIT_RESET;
                        s_d.state   = ST_TX;
                    end
                end
                default: begin
                    s_d.state  = ST_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Pins start idle high: no false edge after reset
            s_q.s1      <= '1;
            s_q.s2      <= '1;
            s_q.prev    <= '1;
            s_q.pwr1    <= 1'b0;
            s_q.pwr2    <= 1'b0;
            s_q.state   <= ST_IDLE;
            s_q.bit_cnt <= BIT_RESET;
            s_q.shreg   <= BYTE_RESET;
            s_q.ptr     <= PTR_RESET;
            s_q.rd_mode <= 1'b0;
            s_q.sda_oe  <= 1'b0;
            s_q.busy    <= 1'b0;
            s_q.offset_next <= 1'b0;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                s_q.mem[i] <= BYTE_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Pin outputs
    always_comb begin
        sda_out     = 1'b0;
        sda_oe      = s_q.sda_oe;
        word_offset = s_q.ptr;
        busy        = s_q.busy;
    end

endmodule : serial_slave_memory_port

//--- hw/serial_port_pkg.sv
// Purpose: Shared constants and types for the two-wire slave memory port
// Assumes: 10 MHz system clock, bus clock from the master
// Notes:   Storage is 64 bytes, clock bytes first, then RAM
package serial_port_pkg;

    localparam logic [6:0] SLAVE_ADDR     = 7'h68;
    localparam int         MEM_DEPTH      = 64;
    localparam int         PTR_W          = 6;
    localparam logic [5:0] PTR_RESET      = 6'h00;
    localparam logic [5:0] PTR_LAST       = 6'h3F;
    localparam logic [7:0] BYTE_RESET     = 8'h00;
    localparam logic [3:0] BIT_LAST       = 4'h7;
    localparam logic [3:0] BIT_RESET      = 4'h0;
    localparam int         RW_BIT         = 0;
    localparam int         CLOCK_BYTES    = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_OFFSET,
        ST_WR_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } port_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

    typedef struct packed {
        logic       wr_en;
        logic [5:0] addr;
        logic [7:0] data;
    } mem_write_t;

endpackage : serial_port_pkg

//--- verif/serial_port_asserts.sv
// Purpose: Pin timing checks for the slave port
// Assumes: Bus pins sampled by clk
// Notes:   Bound to the port top
`timescale 1ns/10ps
module serial_port_asserts
    import serial_port_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       supply_ok,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [5:0] word_offset,
    input wire logic       busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence scl_held;
        (scl_in && supply_ok) [*5];
    endsequence
    sequence stop_seen;
        scl_in [*3] ##1 (scl_in && $rose(sda_in));
    endsequence
    // ==========================================
    // Pin checks
    open_drain_a: assert property (sda_out == 1'b0)
        else $error("data output not low");
    high_stable_a: assert property (scl_held |-> $stable(sda_oe))
        else $error("data moved with clock high");
    ack_stands_a: assert property ($rose(sda_oe) && supply_ok |-> ##1 sda_oe [*5])
        else $error("data drive too short");
    stop_ends_a: assert property (stop_seen |-> ##[1:6] !busy)
        else $error("stop did not end frame");
    supply_release_a: assert property ($fell(supply_ok) |-> ##[1:6] !sda_oe)
        else $error("data held after supply loss");
    supply_ptr_a: assert property (!supply_ok [*6] |-> word_offset == PTR_RESET)
        else $error("pointer kept after supply loss");
    low_quiet_a: assert property (!supply_ok [*6] |-> !busy && !sda_oe)
        else $error("active during low supply");
    ptr_quiet_a: assert property ($changed(word_offset) |->
        busy || $past(busy) || word_offset == PTR_RESET)
        else $error("pointer moved while idle");
    idle_release_a: assert property (!busy [*2] |-> !sda_oe)
        else $error("data driven while idle");
endmodule : serial_port_asserts

bind serial_slave_memory_port serial_port_asserts i_serial_port_asserts (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
    .supply_ok(supply_ok), .sda_out(sda_out), .sda_oe(sda_oe),
    .word_offset(word_offset), .busy(busy));

//--- verif/bus_master_model.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Pull-up on data, 800 ns bus clock
// Notes:   Phase offset keeps bus clock unrelated to clk
`timescale 1ns/10ps
module bus_master_model (
    input  wire logic       clk,
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_low,
    output logic [7:0]      rd_data,
    output logic            rd_stb
);
    initial begin
        {scl, sda_low, rd_stb, rd_data} = 11'h400;
    end
    // data set in clock low, one pulse per bit
    task automatic bit_io(input logic b, output logic r);
        #100 sda_low = !b;
        #300 scl = 1;
        #200 r = sda;
        #200 scl = 0;
    endtask : bit_io
    task automatic start;
        #37 sda_low = 0;
        #100 scl = 1;
        #300 sda_low = 1;
        #300 scl = 0;
    endtask : start
    task automatic stop;
        #100 sda_low = 1;
        #300 scl = 1;
        #300 sda_low = 0;
        #300;
    endtask : stop
    task automatic put(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : put
    // acknowledge the byte only when ack is set
    task automatic get(input logic ack);
        logic [7:0] d;
        logic       r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, r);
        rd_data = d;
        @(posedge clk) rd_stb <= 1;
        @(posedge clk) rd_stb <= 0;
    endtask : get
endmodule : bus_master_model

//--- verif/serial_slave_memory_port_tb.sv
// Purpose: Self-checking bench for the slave port
// Assumes: Master model on the far side
// Notes:   Read data checked through a queue
`timescale 1ns/10ps
module serial_slave_memory_port_tb;
    logic       clk, sys_rst, supply_ok, scl, m_low, sda_out, sda_oe, busy, stb;
    logic [5:0] word_offset;
    logic [7:0] rd, r, d, exp_q[$];
    int         errors, comparisons, seed = 32'hc2242870;
    wire        sda = !(m_low || sda_oe);
    serial_slave_memory_port i_serial_slave_memory_port (.clk(clk), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(sda), .supply_ok(supply_ok), .sda_out(sda_out),
        .sda_oe(sda_oe), .word_offset(word_offset), .busy(busy));
    bus_master_model i_bus_master_model (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(m_low), .rd_data(rd), .rd_stb(stb));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] b, input logic a);
        logic ack;
        i_bus_master_model.put(b, ack);
        check({7'h00, ack}, {7'h00, a});
    endtask : wr
    task automatic rdb(input logic [7:0] e, input logic a);
        exp_q.push_back(e);
        i_bus_master_model.get(a);
    endtask : rdb
    always @(posedge clk) if (stb) check(rd, exp_q.pop_front());
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    initial begin
        #3000000;
        errors++;
        test_done;
    end
    initial begin
        {sys_rst, supply_ok} = 2'b11;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        repeat (6) @(negedge clk);
        i_bus_master_model.start; wr(8'hD0, 1); wr(8'h3E, 1);
        wr(8'hA5, 1); wr(8'h5A, 1); wr(8'hC3, 1); i_bus_master_model.stop;
        check({2'b00, word_offset}, 8'h01);
        $display("write burst done");
        i_bus_master_model.start; wr(8'hD0, 1); wr(8'h3E, 1);
        i_bus_master_model.start; wr(8'hD1, 1);
        rdb(8'hA5, 1); rdb(8'h5A, 1); rdb(8'hC3, 0); i_bus_master_model.stop;
        check({2'b00, word_offset}, 8'h00);
        i_bus_master_model.start; wr(8'hD1, 1); rdb(8'hC3, 0); i_bus_master_model.stop;
        $display("reads done");
        r = 8'($random(seed));
        if (r[7:1] == 7'h68) r ^= 8'h02;
        i_bus_master_model.start; wr(r, 0); wr(8'h55, 0); i_bus_master_model.stop;
        check({7'h00, busy}, 8'h00);
        $display("foreign address done");
        i_bus_master_model.start; wr(8'hD0, 1); wr(8'h10, 1);
        fork
            wr(8'h77, 0);
            begin
                #2037 @(negedge clk) supply_ok = 0;
            end
        join
        check({1'b0, sda_oe, word_offset}, 8'h00);
        i_bus_master_model.stop;
        i_bus_master_model.start; wr(8'hD0, 0); i_bus_master_model.stop;
        @(negedge clk) supply_ok = 1;
        repeat (6) @(negedge clk);
        i_bus_master_model.start; wr(8'hD1, 1); rdb(8'hC3, 0); i_bus_master_model.stop;
        $display("supply loss done");
        repeat (3) begin
            r = 8'($random(seed));
            d = 8'($random(seed));
            i_bus_master_model.start; wr(8'hD0, 1); wr({2'b00, r[5:0]}, 1);
            wr(d, 1); wr(r, 1); i_bus_master_model.stop;
            i_bus_master_model.start; wr(8'hD0, 1); wr({2'b00, r[5:0]}, 1);
            i_bus_master_model.start; wr(8'hD1, 1);
            rdb(d, 1); rdb(r, 0); i_bus_master_model.stop;
        end
        $display("random access done");
        test_done;
    end
endmodule : serial_slave_memory_port_tb
